// [src/epa_regs.sv]
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module epa_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLK,
  input  wire logic              RST_B,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire epa_pkg::epa_otp_s OTP_VAL,
  input  wire logic              ENABLE_PIN_ONE,
  input  wire logic              ENABLE_PIN_TWO,
  input  wire logic              ENABLE_PIN_THREE,
  input  wire epa_pkg::epa_rail_s SW_EN,
  output epa_pkg::epa_rail_s     RAIL_EN,
  output epa_pkg::epa_rail_s     PIN_CTRL
);

  if (ADDR_W < 8)
  begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  logic [7:0]          asg_reg  [epa_pkg::NUM_REGS];
  logic [7:0]          asg_next [epa_pkg::NUM_REGS];
  logic [7:0]          otp_slot [epa_pkg::NUM_REGS];
  logic [epa_pkg::NUM_REGS-1:0] hit;
  epa_pkg::epa_state_e state_reg;
  epa_pkg::epa_state_e state_next;
  logic [2:0]          pin_meta_reg;
  logic [2:0]          pin_sync_reg;
  logic [31:0]         prdata_reg;
  logic [31:0]         prdata_next;
  epa_pkg::epa_rail_s  rail_reg;
  epa_pkg::epa_rail_s  rail_next;
  logic [13:0]         map_one;
  logic [13:0]         map_two;
  logic [13:0]         map_three;
  logic [13:0]         ctrl;
  logic [13:0]         drive;
  wire logic           wr_acc;
  wire logic           rd_setup;
  wire logic           any_hit;
  wire logic [7:0]     rd_byte;
  wire logic [39:0]    asg_flat;

  assign otp_slot[epa_pkg::SLOT_P1_UP] = OTP_VAL.p1_up;
  assign otp_slot[epa_pkg::SLOT_P2_LO] = OTP_VAL.p2_lo;
  assign otp_slot[epa_pkg::SLOT_P2_UP] = OTP_VAL.p2_up;
  assign otp_slot[epa_pkg::SLOT_P3_LO] = OTP_VAL.p3_lo;
  assign otp_slot[epa_pkg::SLOT_P3_UP] = OTP_VAL.p3_up;

  assign wr_acc   = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign any_hit  = |hit;
  assign asg_flat = {asg_reg[0], asg_reg[1], asg_reg[2],
                     asg_reg[3], asg_reg[4]};

  // Register storage and decode, one entry per register
  for (genvar i = 0; i < epa_pkg::NUM_REGS; i++)
  begin : g_reg
    assign hit[i] = (PADDR[1:0] == 2'b00) &&
                    (PADDR[ADDR_W-1:2] ==
                     (ADDR_W-2)'(epa_pkg::REG_IDX[i]));
    // Factory load wins over a bus write in the load cycle
    assign asg_next[i] =
      (state_reg == epa_pkg::EPA_LOAD) ?
        (otp_slot[i] & epa_pkg::REG_MASK[i]) :
      (wr_acc && hit[i]) ?
        (PWDATA[7:0] & epa_pkg::REG_MASK[i]) :
        asg_reg[i];
    always_ff @(posedge CLK or negedge RST_B)
    begin
      if (!RST_B)
        asg_reg[i] <= epa_pkg::PRE_LOAD_VAL;
      else
        asg_reg[i] <= asg_next[i];
    end
  end

  assign state_next = epa_pkg::EPA_RUN;

  // Caught after release, since an async reset may load only constants
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      state_reg <= epa_pkg::EPA_LOAD;
    else
    begin
      case (state_reg)
        epa_pkg::EPA_LOAD: state_reg <= state_next;
        epa_pkg::EPA_RUN:  state_reg <= epa_pkg::EPA_RUN;
        default:           state_reg <= epa_pkg::EPA_LOAD;
      endcase
    end
  end

  assign rd_byte =
    ({8{hit[0]}} & asg_reg[0]) | ({8{hit[1]}} & asg_reg[1]) |
    ({8{hit[2]}} & asg_reg[2]) | ({8{hit[3]}} & asg_reg[3]) |
    ({8{hit[4]}} & asg_reg[4]);

  // Read data is captured in the setup phase so it is a flop output
  assign prdata_next = rd_setup ? {24'h000000, rd_byte} : prdata_reg;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      prdata_reg <= 32'h00000000;
    else
      prdata_reg <= prdata_next;
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !any_hit;

  // Enable pins are asynchronous to CLK
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end
    else
    begin
      pin_meta_reg <= {ENABLE_PIN_THREE, ENABLE_PIN_TWO, ENABLE_PIN_ONE};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Order {dcdc4..1, ldo10..1}; pin one has only its upper register here
  assign map_one   = {asg_reg[epa_pkg::SLOT_P1_UP][5:0], 8'h00};
  assign map_two   = {asg_reg[epa_pkg::SLOT_P2_UP][5:0],
                      asg_reg[epa_pkg::SLOT_P2_LO]};
  assign map_three = {asg_reg[epa_pkg::SLOT_P3_UP][5:0],
                      asg_reg[epa_pkg::SLOT_P3_LO]};

  // Several pins on one output combine as a logical OR
  assign ctrl  = map_one | map_two | map_three;
  assign drive = (map_one & {14{pin_sync_reg[0]}}) |
                 (map_two & {14{pin_sync_reg[1]}}) |
                 (map_three & {14{pin_sync_reg[2]}});
  assign rail_next = (ctrl & drive) | (~ctrl & SW_EN);

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      rail_reg <= '0;
    else
      rail_reg <= rail_next;
  end

  assign RAIL_EN  = rail_reg;
  assign PIN_CTRL = ctrl;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  a_reserved_read_zero: assert property (
    PSEL && PENABLE && !PWRITE &&
    (hit[epa_pkg::SLOT_P2_UP] || hit[epa_pkg::SLOT_P3_UP] ||
     hit[epa_pkg::SLOT_P1_UP]) |-> PRDATA[31:6] == 26'h0)
    else $error("reserved bits read non-zero");

  a_p2_lo_write: assert property (
    wr_acc && PADDR[7:0] == 8'hc4 && state_reg == epa_pkg::EPA_RUN
    |=> asg_reg[epa_pkg::SLOT_P2_LO] == $past(PWDATA[7:0]))
    else $error("pin two low write lost");

  a_p2_up_write: assert property (
    wr_acc && PADDR[7:0] == 8'hc8 && state_reg == epa_pkg::EPA_RUN
    |=> asg_reg[epa_pkg::SLOT_P2_UP] == ($past(PWDATA[7:0]) & 8'h3f))
    else $error("pin two upper write wrong");

  a_p3_lo_write: assert property (
    wr_acc && PADDR[7:0] == 8'hcc && state_reg == epa_pkg::EPA_RUN
    |=> asg_reg[epa_pkg::SLOT_P3_LO] == $past(PWDATA[7:0]))
    else $error("pin three low write lost");

  a_p3_up_readback: assert property (
    wr_acc && PADDR[7:0] == 8'hd0 && state_reg == epa_pkg::EPA_RUN
    ##1 !(wr_acc && any_hit) [*2] ##1 PSEL && PENABLE && !PWRITE &&
    PADDR[7:0] == 8'hd0 |-> PRDATA[7:0] == ($past(PWDATA[7:0], 3) & 8'h3f))
    else $error("pin three upper readback wrong");

  a_p1_up_write: assert property (
    wr_acc && PADDR[7:0] == 8'hc0 && state_reg == epa_pkg::EPA_RUN
    |=> PIN_CTRL.dcdc[1:0] == $past(PWDATA[3:2]) ||
        asg_reg[epa_pkg::SLOT_P2_UP][3:2] != 2'b00 ||
        asg_reg[epa_pkg::SLOT_P3_UP][3:2] != 2'b00)
    else $error("pin one upper write not applied");

  a_load_factory: assert property (
    state_reg == epa_pkg::EPA_LOAD |=>
    asg_reg[epa_pkg::SLOT_P2_LO] == $past(OTP_VAL.p2_lo) &&
    asg_reg[epa_pkg::SLOT_P3_UP] == ($past(OTP_VAL.p3_up) & 8'h3f))
    else $error("factory values not loaded");

  a_unmapped_err: assert property (
    PSEL && PENABLE && PADDR[7:0] == 8'hd4 |-> PSLVERR)
    else $error("unmapped address accepted");

  // Pin checks rebuild the enable from the registers, not from drive
  a_pin_drive: assert property (
    ctrl[0] |=> RAIL_EN.ldo[0] ==
      $past(asg_reg[epa_pkg::SLOT_P2_LO][0] && pin_sync_reg[1] ||
            asg_reg[epa_pkg::SLOT_P3_LO][0] && pin_sync_reg[2]))
    else $error("assigned pin not driving enable");

  a_sw_hold: assert property (
    !ctrl[0] |=> RAIL_EN.ldo[0] == $past(SW_EN.ldo[0]))
    else $error("unassigned output not left to software");

  a_conv_drive: assert property (
    ctrl[10] |=> RAIL_EN.dcdc[0] ==
      $past(asg_reg[epa_pkg::SLOT_P1_UP][2] && pin_sync_reg[0] ||
            asg_reg[epa_pkg::SLOT_P2_UP][2] && pin_sync_reg[1] ||
            asg_reg[epa_pkg::SLOT_P3_UP][2] && pin_sync_reg[2]))
    else $error("assigned pin not driving converter");

  a_sw_conv_hold: assert property (
    !ctrl[13] |=> RAIL_EN.dcdc[3] == $past(SW_EN.dcdc[3]))
    else $error("unassigned converter not left to software");

  a_load_all: assert property (
    state_reg == epa_pkg::EPA_LOAD |=>
    asg_flat == {$past(OTP_VAL.p1_up) & 8'h3f, $past(OTP_VAL.p2_lo),
                 $past(OTP_VAL.p2_up) & 8'h3f, $past(OTP_VAL.p3_lo),
                 $past(OTP_VAL.p3_up) & 8'h3f})
    else $error("factory values not loaded in full");

  a_misaligned_err: assert property (
    PSEL && PENABLE && PADDR[1:0] != 2'b00 |-> PSLVERR)
    else $error("misaligned address accepted");

  a_bad_write_kept: assert property (
    wr_acc && !any_hit && state_reg == epa_pkg::EPA_RUN
    |=> $stable(asg_flat))
    else $error("unmapped write changed a register");

  a_write_no_alias: assert property (
    wr_acc && hit[epa_pkg::SLOT_P2_LO] && state_reg == epa_pkg::EPA_RUN
    |=> $stable(asg_reg[epa_pkg::SLOT_P3_LO]) &&
        $stable(asg_reg[epa_pkg::SLOT_P2_UP]))
    else $error("write spilled into a neighbour");

  a_reserved_store_zero: assert property (
    asg_flat[39:38] == 2'b00 && asg_flat[23:22] == 2'b00 &&
    asg_flat[7:6] == 2'b00)
    else $error("reserved bits stored");

  a_unmapped_rdata: assert property (
    rd_setup && !any_hit |=> PRDATA == 32'h00000000)
    else $error("unmapped read returned data");

  a_p2_lo_read: assert property (
    rd_setup && PADDR[7:0] == 8'hc4
    |=> PRDATA == {24'h000000, $past(asg_reg[epa_pkg::SLOT_P2_LO])})
    else $error("pin two low read wrong");

  a_p1_up_read: assert property (
    rd_setup && PADDR[7:0] == 8'hc0
    |=> PRDATA == {24'h000000, $past(asg_reg[epa_pkg::SLOT_P1_UP])})
    else $error("pin one upper read wrong");

  a_idle_no_err: assert property (
    !(PSEL && PENABLE) |-> !PSLVERR)
    else $error("error flagged outside an access");

  a_p1_grant_shown: assert property (
    (asg_reg[epa_pkg::SLOT_P1_UP][3:0] &
     ~{PIN_CTRL.dcdc[1:0], PIN_CTRL.ldo[9:8]}) == 4'h0)
    else $error("pin one grant missing from owner map");

  a_low_map_only: assert property (
    PIN_CTRL.ldo[7:0] == (asg_reg[epa_pkg::SLOT_P2_LO] |
                          asg_reg[epa_pkg::SLOT_P3_LO]))
    else $error("low regulator owners wrong");

  // Scenarios the bench is expected to reach

  c_write_read: cover property (
    wr_acc && hit[epa_pkg::SLOT_P2_LO] ##[1:4]
    PSEL && PENABLE && !PWRITE && hit[epa_pkg::SLOT_P2_LO]);
  c_pin_three_on: cover property (
    map_three[10] && $rose(RAIL_EN.dcdc[0]));
  c_bad_addr: cover property (PSLVERR);
  c_misaligned: cover property (PSLVERR && PADDR[1:0] != 2'b00);
  c_reload: cover property (
    state_reg == epa_pkg::EPA_LOAD ##1 state_reg == epa_pkg::EPA_RUN);

endmodule
`default_nettype wire

// [src/epa_pkg.sv]
package epa_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_P1_UP = 8'h30;
  localparam logic [7:0] IDX_P2_LO = 8'h31;
  localparam logic [7:0] IDX_P2_UP = 8'h32;
  localparam logic [7:0] IDX_P3_LO = 8'h33;
  localparam logic [7:0] IDX_P3_UP = 8'h34;

  localparam int NUM_REGS = 5;
  // Storage slot of each register
  localparam int SLOT_P1_UP = 0;
  localparam int SLOT_P2_LO = 1;
  localparam int SLOT_P2_UP = 2;
  localparam int SLOT_P3_LO = 3;
  localparam int SLOT_P3_UP = 4;

  localparam logic [7:0] REG_IDX [NUM_REGS] =
    '{IDX_P1_UP, IDX_P2_LO, IDX_P2_UP, IDX_P3_LO, IDX_P3_UP};

  // Writable bits; bits 7:6 of upper registers are reserved, read zero
  localparam logic [7:0] MASK_LO = 8'hff;
  localparam logic [7:0] MASK_UP = 8'h3f;
  localparam logic [7:0] REG_MASK [NUM_REGS] =
    '{MASK_UP, MASK_LO, MASK_UP, MASK_LO, MASK_UP};

  // Upper register fields
  localparam int UP_LDO9_POS  = 0;
  localparam int UP_LDO10_POS = 1;
  localparam int UP_DCDC_LSB  = 2;
  localparam int UP_RESERVED_LSB = 6;

  // Value held from reset assertion until the factory values are loaded
  localparam logic [7:0] PRE_LOAD_VAL = 8'h00;

  typedef struct packed {
    logic [3:0] dcdc;
    logic [9:0] ldo;
  } epa_rail_s;

  typedef struct packed {
    logic [7:0] p1_up;
    logic [7:0] p2_lo;
    logic [7:0] p2_up;
    logic [7:0] p3_lo;
    logic [7:0] p3_up;
  } epa_otp_s;

  typedef enum logic {EPA_LOAD, EPA_RUN} epa_state_e;

endpackage

// [sim/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} epa_row_s;
  logic               clk, rst_b, psel, penable, pwrite, err, pin1, pin2, pin3;
  logic               pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  epa_pkg::epa_otp_s  otp;
  epa_pkg::epa_rail_s sw_en, rail_en, pin_ctrl;
  int                 n_mismatch, n_tests;
  // Last row: a lone reserved bit must not stick
  epa_row_s rows [6] = '{'{8'h31, 8'hff, 8'hff}, '{8'h32, 8'hff, 8'h3f},
    '{8'h33, 8'h3c, 8'h3c}, '{8'h34, 8'hc5, 8'h05}, '{8'h30, 8'hcf, 8'h0f},
    '{8'h32, 8'h40, 8'h00}};

  epa_regs DUT (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .OTP_VAL(otp),
    .ENABLE_PIN_ONE(pin1), .ENABLE_PIN_TWO(pin2), .ENABLE_PIN_THREE(pin3),
    .SW_EN(sw_en), .RAIL_EN(rail_en), .PIN_CTRL(pin_ctrl));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] ex, input string m);
    n_tests++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, ex);
    end
  endtask

  // Index to byte address: printed offsets are word indices
  function automatic logic [7:0] ad(input logic [7:0] i);
    return i << 2;
  endfunction

  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task chk_otp;
    logic [7:0] fx;
    for (int s = 0; s < 5; s++)
    begin
      fx = otp[39-8*s -: 8] & epa_pkg::REG_MASK[s];
      apb(1'b0, ad(epa_pkg::REG_IDX[s]), 8'h0);
      chk(rd, {24'h0, fx}, "factory");
    end
  endtask

  initial
  begin
    #100000;
    n_mismatch++;
    give_verdict;
  end

  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pin1 = 1'b0;
    pin2 = 1'b0;
    pin3 = 1'b0;
    sw_en = 14'h1555;
    otp = {8'hff, 8'ha5, 8'hc3, 8'h5a, 8'h7e};
    n_mismatch = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    chk_otp;
    chk({18'h0, pin_ctrl}, 32'h3fff, "owner after load");
    $display("test reset load done");
    foreach (rows[k])
    begin
      apb(1'b1, ad(rows[k].idx), rows[k].wd);
      apb(1'b0, ad(rows[k].idx), 8'h0);
      chk({err, rd[30:0]}, {24'h0, rows[k].ex}, "row");
    end
    $display("test register rows done");
    // Misaligned access must not alias onto the word below it
    for (int j = 0; j < 2; j++)
    begin
      apb(1'b1, j ? 8'hc5 : 8'hd4, 8'h00);
      apb(1'b0, j ? 8'hc5 : 8'hd4, 8'h0);
      chk({err, rd[30:0]}, 32'h8000_0000, "unmapped");
    end
    apb(1'b0, ad(8'h31), 8'h0);
    chk(rd, 32'hff, "after unmapped");
    $display("test unmapped done");
    apb(1'b1, ad(8'h30), 8'h02);
    apb(1'b1, ad(8'h31), 8'h01);
    apb(1'b1, ad(8'h32), 8'h20);
    apb(1'b1, ad(8'h33), 8'h80);
    apb(1'b1, ad(8'h34), 8'h04);
    // The last write lands on the edge at which the task returns
    @(posedge clk);
    chk({18'h0, pin_ctrl}, 32'h2681, "owner map");
    for (int k = 0; k < 8; k++)
    begin
      {pin3, pin2, pin1} <= k[2:0];
      // Two sync stages plus the output flop, one spare edge
      repeat (4) @(posedge clk);
      chk({18'h0, rail_en}, {18'h0, (sw_en & ~14'h2681)
        | (pin1 ? 14'h0200 : 14'h0) | (pin2 ? 14'h2001 : 14'h0)
        | (pin3 ? 14'h0480 : 14'h0)}, "rail enable");
    end
    $display("test pin control done");
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    chk({18'h0, pin_ctrl}, 32'h0, "owner in reset");
    rst_b <= 1'b1;
    chk_otp;
    $display("test second reset done");
    give_verdict;
  end
endmodule
`default_nettype wire
